/* core/ext_edge_detect.sv */
// edge detector for the external request pin with selectable edge
// assumes the pin is already synchronous to i_clock
`timescale 1ns/1ps
module ext_edge_detect
	import irq_ctl_pkg::*;
(
	input  wire logic                       i_clock,
	input  wire logic                       i_nrst,
	input  wire logic                       i_clk_en,
	input  wire logic                       i_pin,
	input  wire irq_ctl_pkg::edge_mode_type i_mode,
	output logic                            o_hit
);
	import irq_ctl_pkg::*;

	logic prev_q;
	logic valid_q;
	wire  rise_w = valid_q & i_pin & ~prev_q;
	wire  fall_w = valid_q & ~i_pin & prev_q;

	// first enabled cycle only loads, so a high pin at release is no edge
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_q  <= 1'b0;
			valid_q <= 1'b0;
		end else if (i_clk_en) begin
			prev_q  <= i_pin;
			valid_q <= 1'b1;
		end
	end

	// edge choice, both codes with bit 1 set mean either edge
	assign o_hit = i_mode[1] ? (rise_w | fall_w) :
	               (i_mode == EDGE_FALL) ? fall_w : rise_w;
endmodule

/* core/irq_ctl_pkg.sv */
// constants, types and helpers for the vectored interrupt flag control
// assumes one system clock; register file addresses are six bits wide
package irq_ctl_pkg;

	localparam int unsigned N_SRC = 5;

	typedef logic [5:0]  rf_addr_type;
	typedef logic [3:0]  nibble_type;
	typedef logic [15:0] vector_type;
	typedef logic [4:0]  src_vec_type;
	typedef logic [1:0]  edge_mode_type;

	// register file addresses
	localparam rf_addr_type ADDR_PIN_LEVEL = 6'h0f;
	localparam rf_addr_type ADDR_EDGE_SEL  = 6'h1f;
	localparam rf_addr_type ADDR_ENABLE_A  = 6'h2f;
	localparam rf_addr_type ADDR_ENABLE_B  = 6'h2e;
	localparam rf_addr_type ADDR_T0_REQ    = 6'h3e;
	localparam rf_addr_type ADDR_EXT_REQ   = 6'h3f;

	// source positions in every five-bit source vector, highest priority first
	localparam int unsigned SRC_EXT    = 0;
	localparam int unsigned SRC_T0     = 1;
	localparam int unsigned SRC_T1     = 2;
	localparam int unsigned SRC_TICK   = 3;
	localparam int unsigned SRC_SERIAL = 4;

	// branch targets per source
	localparam vector_type VEC_EXT    = 16'h0005;
	localparam vector_type VEC_T0     = 16'h0004;
	localparam vector_type VEC_T1     = 16'h0003;
	localparam vector_type VEC_TICK   = 16'h0002;
	localparam vector_type VEC_SERIAL = 16'h0001;
	localparam vector_type VEC_NONE   = 16'h0000;

	// edge select encodings; bit 1 set means both edges
	localparam edge_mode_type EDGE_RISE = 2'h0;
	localparam edge_mode_type EDGE_FALL = 2'h1;

	// values after reset
	localparam edge_mode_type EDGE_SEL_RESET = 2'h0;
	localparam src_vec_type   FLAG_RESET     = 5'h00;
	localparam src_vec_type   ENABLE_RESET   = 5'h00;
	localparam nibble_type    NIBBLE_ZERO    = 4'h0;
	localparam vector_type    VECTOR_RESET   = 16'h0000;

	// one register file access per cycle
	typedef struct packed {
		logic        rd;
		logic        wr;
		rf_addr_type addr;
		nibble_type  wdata;
	} rf_req_type;

	// one-cycle set pulses from the internal peripherals
	typedef struct packed {
		logic serial_done;
		logic tick_overflow;
		logic timer1_match;
		logic timer0_match;
	} src_events_type;

	function automatic logic rf_hit(input rf_addr_type a, input rf_addr_type b);
		return a == b;
	endfunction

endpackage

/* core/irq_priority.sv */
// fixed priority pick among pending enabled sources
// purely combinational; the caller registers the result
`timescale 1ns/1ps
module irq_priority
	import irq_ctl_pkg::*;
(
	input  wire irq_ctl_pkg::src_vec_type i_pending,
	output irq_ctl_pkg::src_vec_type      o_grant,
	output irq_ctl_pkg::vector_type       o_vector
);
	import irq_ctl_pkg::*;

	// lowest index wins; only one grant bit is ever set
	always_comb begin
		o_grant = '0;
		if (i_pending[SRC_EXT])
			o_grant[SRC_EXT] = 1'b1;
		else if (i_pending[SRC_T0])
			o_grant[SRC_T0] = 1'b1;
		else if (i_pending[SRC_T1])
			o_grant[SRC_T1] = 1'b1;
		else if (i_pending[SRC_TICK])
			o_grant[SRC_TICK] = 1'b1;
		else if (i_pending[SRC_SERIAL])
			o_grant[SRC_SERIAL] = 1'b1;
	end

	always_comb begin
		case (o_grant)
			5'h01:   o_vector = VEC_EXT;
			5'h02:   o_vector = VEC_T0;
			5'h04:   o_vector = VEC_T1;
			5'h08:   o_vector = VEC_TICK;
			5'h10:   o_vector = VEC_SERIAL;
			default: o_vector = VEC_NONE;
		endcase
	end
endmodule

/* core/vectored_irq_flag_control.sv */
// interrupt flag control: accept gate, request and enable flags, edge select
// assumes the core pulses the unmask and mask ops and samples o_accept/o_vector
//
// Summary of operation
// - unmask op sets the accept gate
// - any acceptance clears the accept gate
// - accept gate has no register file address
// - mask op clears the accept gate
// - reset clears the accept gate
// - selected pin edge sets external request flag
// - timer 0 match sets its flag
// - timer 1 match sets its flag
// - tick timer overflow sets its flag
// - serial end signal sets its flag
// - pin status read shows live pin level
// - external flag holds until accepted or cleared
// - writes to pin status address ignored
// - edge select field, rising, falling, both
// - external flag readable at its address
// - write 0 cancels, write 1 forces external
// - timer 0 flag readable, writable, forced
// - timer 0 clear control clears its flag
// - acceptance clears that source's flag
// - per-source enable flag gates acceptance
// - fixed priority, vectors 0005H down to 0001H
`timescale 1ns/1ps
module vectored_irq_flag_control
	import irq_ctl_pkg::*;
(
	input  wire logic                        i_clock,
	input  wire logic                        i_nrst,
	input  wire logic                        i_clk_en,
	input  wire logic                        i_ext_pin,
	input  wire irq_ctl_pkg::src_events_type i_events,
	input  wire logic                        i_timer0_clear,
	input  wire logic                        i_global_unmask_op,
	input  wire logic                        i_global_mask_op,
	input  wire logic                        i_accept_allowed,
	input  wire irq_ctl_pkg::rf_req_type     i_rf,
	output irq_ctl_pkg::nibble_type          o_rf_rdata,
	output logic                             o_accept,
	output irq_ctl_pkg::vector_type          o_vector
);
	import irq_ctl_pkg::*;

	logic          gate_q;
	logic          gate_d;
	src_vec_type   flag_q;
	src_vec_type   flag_d;
	src_vec_type   enable_q;
	src_vec_type   enable_d;
	edge_mode_type edge_sel_q;
	edge_mode_type edge_sel_d;
	nibble_type    rdata_d;

	wire           edge_hit_w;
	src_vec_type   grant_w;
	vector_type    vector_w;

	// edge detection for the external pin, mode from the edge select field
	ext_edge_detect u_edge (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_clk_en(i_clk_en),
		.i_pin   (i_ext_pin),
		.i_mode  (edge_sel_q),
		.o_hit   (edge_hit_w)
	);

	// register file decode; 0FH has no write strobe at all
	wire wr_edge_w  = i_rf.wr & rf_hit(i_rf.addr, ADDR_EDGE_SEL);
	wire wr_en_a_w  = i_rf.wr & rf_hit(i_rf.addr, ADDR_ENABLE_A);
	wire wr_en_b_w  = i_rf.wr & rf_hit(i_rf.addr, ADDR_ENABLE_B);
	wire wr_t0_w    = i_rf.wr & rf_hit(i_rf.addr, ADDR_T0_REQ);
	wire wr_ext_w   = i_rf.wr & rf_hit(i_rf.addr, ADDR_EXT_REQ);
	wire rd_pin_w   = i_rf.rd & rf_hit(i_rf.addr, ADDR_PIN_LEVEL);  // read only
	wire rd_edge_w  = i_rf.rd & rf_hit(i_rf.addr, ADDR_EDGE_SEL);
	wire rd_en_a_w  = i_rf.rd & rf_hit(i_rf.addr, ADDR_ENABLE_A);
	wire rd_en_b_w  = i_rf.rd & rf_hit(i_rf.addr, ADDR_ENABLE_B);
	wire rd_t0_w    = i_rf.rd & rf_hit(i_rf.addr, ADDR_T0_REQ);
	wire rd_ext_w   = i_rf.rd & rf_hit(i_rf.addr, ADDR_EXT_REQ);

	// set sources per flag; write 1 acts as a forced request
	wire src_vec_type set_w = {
		i_events.serial_done,
		i_events.tick_overflow,
		i_events.timer1_match,
		i_events.timer0_match | (wr_t0_w & i_rf.wdata[0]),
		edge_hit_w | (wr_ext_w & i_rf.wdata[0])
	};

	// clear sources per flag: service, cancel write, timer 0 clear control
	wire accept_w = gate_q & i_accept_allowed & ~i_global_mask_op & (|grant_w);
	wire src_vec_type service_w = accept_w ? grant_w : 5'h00;
	wire src_vec_type clr_w = service_w | {
		3'h0,
		(wr_t0_w & ~i_rf.wdata[0]) | i_timer0_clear,
		wr_ext_w & ~i_rf.wdata[0]
	};

	// pending only when flag and per-source enable are both 1
	wire src_vec_type pending_w = flag_q & enable_q;

	irq_priority u_prio (
		.i_pending(pending_w),
		.o_grant  (grant_w),
		.o_vector (vector_w)
	);

	// set beats clear so a request in the clearing cycle is kept
	assign flag_d = set_w | (flag_q & ~clr_w);

	// gate: acceptance and mask beat unmask, the safe way to resolve a clash
	assign gate_d = (accept_w | i_global_mask_op) ? 1'b0 :
	                i_global_unmask_op ? 1'b1 : gate_q;

	assign enable_d = {
		wr_en_b_w ? i_rf.wdata[0] : enable_q[SRC_SERIAL],
		wr_en_a_w ? i_rf.wdata : enable_q[3:0]
	};
	assign edge_sel_d = wr_edge_w ? i_rf.wdata[1:0] : edge_sel_q;

	// read mux; the gate has no address, unmapped reads give zero
	assign rdata_d = rd_pin_w  ? {3'h0, i_ext_pin} :
	                 rd_edge_w ? {2'h0, edge_sel_q} :
	                 rd_en_a_w ? enable_q[3:0] :
	                 rd_en_b_w ? {3'h0, enable_q[SRC_SERIAL]} :
	                 rd_t0_w   ? {3'h0, flag_q[SRC_T0]} :
	                 rd_ext_w  ? {3'h0, flag_q[SRC_EXT]} :
	                 NIBBLE_ZERO;

	// control state
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			gate_q     <= 1'b0;
			flag_q     <= FLAG_RESET;
			enable_q   <= ENABLE_RESET;
			edge_sel_q <= EDGE_SEL_RESET;
		end else if (i_clk_en) begin
			gate_q     <= gate_d;
			flag_q     <= flag_d;
			enable_q   <= enable_d;
			edge_sel_q <= edge_sel_d;
		end
	end

	// registered outputs; o_accept is a one-cycle pulse with its vector
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rf_rdata <= NIBBLE_ZERO;
			o_accept   <= 1'b0;
			o_vector   <= VECTOR_RESET;
		end else if (i_clk_en) begin
			o_rf_rdata <= rdata_d;
			o_accept   <= accept_w;
			o_vector   <= accept_w ? vector_w : o_vector;
		end
	end

	// checks
	a_unmask_sets_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && i_global_unmask_op && !i_global_mask_op && !accept_w |=> gate_q)
		else $error("unmask op did not set gate");

	a_accept_clears_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && accept_w |=> !gate_q && o_accept)
		else $error("acceptance left gate set");

	a_mask_clears_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && i_global_mask_op |=> !gate_q)
		else $error("mask op did not clear gate");

	a_accept_needs_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
		$rose(o_accept) |-> $past(gate_q) && ($past(pending_w) != 5'h00))
		else $error("accepted without gate or pending source");

	a_timer0_match_sets: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && i_events.timer0_match |=> flag_q[SRC_T0])
		else $error("timer 0 match lost");

	a_pin_edge_sets: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && edge_hit_w |=> flag_q[SRC_EXT])
		else $error("pin edge did not set external flag");

	a_ext_flag_holds: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && flag_q[SRC_EXT] && !service_w[SRC_EXT] && !wr_ext_w |=> flag_q[SRC_EXT])
		else $error("external flag dropped without cause");

	a_t0_clear_ctl: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && i_timer0_clear && !set_w[SRC_T0] |=> !flag_q[SRC_T0])
		else $error("timer 0 clear control ignored");

	a_pin_read_live: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && rd_pin_w |=> o_rf_rdata == {3'h0, $past(i_ext_pin)})
		else $error("pin status read wrong");

	a_ext_top_priority: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && accept_w && pending_w[SRC_EXT] |=> o_vector == VEC_EXT ##1 1'b1)
		else $error("external source not served first");

	a_service_clears: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && service_w[SRC_TICK] && !i_events.tick_overflow |=> !flag_q[SRC_TICK])
		else $error("serviced tick flag not cleared");

	// acceptance blocked without gate, with mask, or with nothing enabled
	a_gate_low_blocks: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && !gate_q |=> !o_accept)
		else $error("accepted while gate was clear");

	a_mask_blocks: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && i_global_mask_op |=> !o_accept)
		else $error("accepted in a mask op cycle");

	a_enable_blocks: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && ((flag_q & enable_q) == 5'h00) |=> !o_accept)
		else $error("accepted with no enabled request");

	a_accept_one_cycle: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && o_accept |=> !o_accept)
		else $error("acceptance pulse longer than one cycle");

	// vector follows the highest pending enabled source
	a_one_grant: assert property (@(posedge i_clock) disable iff (!i_nrst)
		$onehot0(grant_w))
		else $error("more than one source granted");

	a_t0_priority: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && accept_w && (pending_w[1:0] == 2'h2) |=> o_vector == VEC_T0)
		else $error("timer 0 vector wrong");

	a_t1_priority: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && accept_w && (pending_w[2:0] == 3'h4) |=> o_vector == VEC_T1)
		else $error("timer 1 vector wrong");

	a_tick_priority: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && accept_w && (pending_w[3:0] == 4'h8) |=> o_vector == VEC_TICK)
		else $error("tick timer vector wrong");

	a_serial_priority: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && accept_w && (pending_w == 5'h10) |=> o_vector == VEC_SERIAL)
		else $error("serial vector wrong");

	// peripheral events always land in their flags
	a_t1_match_sets: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && i_events.timer1_match |=> flag_q[SRC_T1])
		else $error("timer 1 match lost");

	a_tick_sets: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && i_events.tick_overflow |=> flag_q[SRC_TICK])
		else $error("tick overflow lost");

	a_serial_sets: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && i_events.serial_done |=> flag_q[SRC_SERIAL])
		else $error("serial end lost");

	// register file writes and reads
	a_ext_force: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && wr_ext_w && i_rf.wdata[0] |=> flag_q[SRC_EXT])
		else $error("forced external request lost");

	a_ext_cancel: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && wr_ext_w && !i_rf.wdata[0] && !edge_hit_w |=> !flag_q[SRC_EXT])
		else $error("external cancel ignored");

	a_t0_force: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && wr_t0_w && i_rf.wdata[0] |=> flag_q[SRC_T0])
		else $error("forced timer 0 request lost");

	a_t0_cancel: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && wr_t0_w && !i_rf.wdata[0] && !i_events.timer0_match |=> !flag_q[SRC_T0])
		else $error("timer 0 cancel ignored");

	a_edge_sel_write: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && wr_edge_w |=> edge_sel_q == $past(i_rf.wdata[1:0]))
		else $error("edge select write lost");

	a_ext_read: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && rd_ext_w |=> o_rf_rdata == {3'h0, $past(flag_q[SRC_EXT])})
		else $error("external flag read wrong");

	a_t0_read: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && rd_t0_w |=> o_rf_rdata == {3'h0, $past(flag_q[SRC_T0])})
		else $error("timer 0 flag read wrong");

	a_pin_write_ignored: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && i_rf.wr && rf_hit(i_rf.addr, ADDR_PIN_LEVEL) |=> $stable(enable_q) && $stable(edge_sel_q))
		else $error("write to pin status changed state");

	a_unmapped_zero: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && i_rf.rd && !rd_pin_w && !rd_edge_w && !rd_en_a_w && !rd_en_b_w && !rd_t0_w && !rd_ext_w
		|=> o_rf_rdata == NIBBLE_ZERO)
		else $error("unmapped read not zero");

	// service clears the flag of the source taken
	a_service_ext: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && service_w[SRC_EXT] && !set_w[SRC_EXT] |=> !flag_q[SRC_EXT])
		else $error("serviced external flag not cleared");

	a_service_t0: assert property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && service_w[SRC_T0] && !set_w[SRC_T0] |=> !flag_q[SRC_T0])
		else $error("serviced timer 0 flag not cleared");

	// enable low must freeze gate, flags, read data and vector
	a_freeze_holds: assert property (@(posedge i_clock) disable iff (!i_nrst) // clock enable freeze
		!i_clk_en |=> $stable(gate_q) && $stable(flag_q) && $stable(o_rf_rdata) && $stable(o_vector))
		else $error("state moved while clock enable low");

	c_accept_ext: cover property (@(posedge i_clock) disable iff (!i_nrst)
		o_accept && o_vector == VEC_EXT);
	c_accept_serial: cover property (@(posedge i_clock) disable iff (!i_nrst)
		o_accept && o_vector == VEC_SERIAL);
	c_forced_ext: cover property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && wr_ext_w && i_rf.wdata[0]);
	c_both_edges: cover property (@(posedge i_clock) disable iff (!i_nrst)
		i_clk_en && edge_sel_q[1] && edge_hit_w && !i_ext_pin);
	c_accept_t0: cover property (@(posedge i_clock) disable iff (!i_nrst)
		o_accept && o_vector == VEC_T0);
endmodule

/* testbench/periph_core_model.sv */
// far side model: peripherals that pulse set events, core that allows branches
// assumes the bench asks for events one cycle ahead on i_fire
`timescale 1ns/1ps
module periph_core_model
	import irq_ctl_pkg::*;
(
	input  wire logic                    i_clock,
	input  wire logic                    i_nrst,
	input  wire logic [3:0]              i_fire,
	output irq_ctl_pkg::src_events_type  o_events,
	output logic                         o_accept_allowed
);
	import irq_ctl_pkg::*;
	logic [1:0] slot_q;

	// one-cycle event pulses; core busy one cycle in four, so waits are not instant
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_events <= '0;
			slot_q   <= 2'h0;
		end else begin
			o_events <= src_events_type'(i_fire);
			slot_q   <= slot_q + 2'h1;
		end
	end
	assign o_accept_allowed = (slot_q != 2'h3); // not every cycle is a boundary
endmodule

/* testbench/vectored_irq_flag_control_tb_top.sv */
// self-checking bench for the interrupt flag control
// assumes the design package and the far side model are compiled first
`timescale 1ns/1ps
module vectored_irq_flag_control_tb_top;
	import irq_ctl_pkg::*;
	logic        i_clock, i_nrst, i_ext_pin, i_timer0_clear, unmask, mask, clk_en;
	logic [3:0]  fire;
	rf_req_type  i_rf;
	src_events_type ev;
	logic        allowed, o_accept;
	nibble_type  o_rf_rdata, rd;
	vector_type  o_vector;
	int          n_fail, cmp_count;
	logic [1:0]  exp_ev [4] = '{2'b11, 2'b01, 2'b11, 2'b11};

	vectored_irq_flag_control u_vectored_irq_flag_control (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_clk_en(clk_en), .i_ext_pin(i_ext_pin), .i_events(ev), .i_timer0_clear(i_timer0_clear),
		.i_global_unmask_op(unmask), .i_global_mask_op(mask), .i_accept_allowed(allowed),
		.i_rf(i_rf), .o_rf_rdata(o_rf_rdata), .o_accept(o_accept), .o_vector(o_vector));
	periph_core_model u_periph_core_model (.i_clock(i_clock), .i_nrst(i_nrst), .i_fire(fire),
		.o_events(ev), .o_accept_allowed(allowed));

	// 20 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
			n_fail++;
		end
	endtask

	// one register file access; read data lands one cycle after it is taken
	task automatic rf(input logic wr, input rf_addr_type a, input nibble_type d);
		@(posedge i_clock) i_rf <= '{rd: ~wr, wr: wr, addr: a, wdata: d};
		@(posedge i_clock) i_rf <= '0;
		#1 rd = o_rf_rdata;
	endtask

	task automatic rd_chk(input string what, input rf_addr_type a, input nibble_type e);
		rf(1'b0, a, 4'h0);
		check(what, {12'h000, rd}, {12'h000, e});
	endtask

	// one-cycle pulse on the unmask or mask op
	task automatic op(input bit is_mask);
		@(posedge i_clock) begin
			if (is_mask) mask <= 1'b1;
			else unmask <= 1'b1;
		end
		@(posedge i_clock) {mask, unmask} <= 2'b00;
	endtask

	// bounded watch for an acceptance pulse
	task automatic wait_acc(input bit want, input vector_type v);
		bit seen;
		seen = 1'b0;
		repeat (8) begin
			@(posedge i_clock) #1;
			if (o_accept === 1'b1 && !seen) begin
				seen = 1'b1;
				if (want) check("vector", o_vector, v);
			end
		end
		check("accepted", 16'(seen), 16'(want));
	endtask

	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end

	initial begin
		{i_ext_pin, i_timer0_clear, unmask, mask} = 4'h0;
		fire = 4'h0;
		clk_en = 1'b1;
		i_rf = '0;
		i_nrst = 1'b0;
		repeat (20) @(posedge i_clock);
		i_nrst <= 1'b1;
		// reset values, read-only pin level, unmapped address
		rd_chk("edge sel rst", ADDR_EDGE_SEL, 4'h0);
		rd_chk("ext flag rst", ADDR_EXT_REQ, 4'h0);
		rd_chk("t0 flag rst", ADDR_T0_REQ, 4'h0);
		rd_chk("unmapped", 6'h10, 4'h0);
		@(posedge i_clock) i_ext_pin <= 1'b1;
		rf(1'b1, ADDR_PIN_LEVEL, 4'h0);
		rd_chk("pin level 1", ADDR_PIN_LEVEL, 4'h1);
		@(posedge i_clock) i_ext_pin <= 1'b0;
		rd_chk("pin level 0", ADDR_PIN_LEVEL, 4'h0);
		rf(1'b1, ADDR_EXT_REQ, 4'h0);
		$display("test registers done");
		// gate: reset, unmask, auto clear, enables, mask
		rf(1'b1, ADDR_ENABLE_A, 4'hf);
		rf(1'b1, ADDR_ENABLE_B, 4'h1);
		rf(1'b1, ADDR_EXT_REQ, 4'h1);
		rd_chk("ext forced", ADDR_EXT_REQ, 4'h1);
		wait_acc(1'b0, VEC_NONE);
		op(1'b0);
		wait_acc(1'b1, 16'h0005);
		rd_chk("ext serviced", ADDR_EXT_REQ, 4'h0);
		rf(1'b1, ADDR_EXT_REQ, 4'h1);
		wait_acc(1'b0, VEC_NONE);
		rf(1'b1, ADDR_ENABLE_A, 4'h0);
		op(1'b0);
		wait_acc(1'b0, VEC_NONE);
		op(1'b1);
		rf(1'b1, ADDR_ENABLE_A, 4'hf);
		wait_acc(1'b0, VEC_NONE);
		op(1'b0);
		wait_acc(1'b1, 16'h0005);
		$display("test gate done");
		// all sources pending at once, served in fixed order
		@(posedge i_clock) fire <= 4'hf;
		@(posedge i_clock) fire <= 4'h0;
		rf(1'b1, ADDR_EXT_REQ, 4'h1);
		for (int k = 0; k < 5; k++) begin
			op(1'b0);
			wait_acc(1'b1, 16'h0005 - 16'(k));
		end
		$display("test priority done");
		// timer 0 flag: set by match, clear control, forced, cancelled
		@(posedge i_clock) fire <= 4'h1;
		@(posedge i_clock) fire <= 4'h0;
		rd_chk("t0 match", ADDR_T0_REQ, 4'h1);
		@(posedge i_clock) i_timer0_clear <= 1'b1;
		@(posedge i_clock) i_timer0_clear <= 1'b0;
		rd_chk("t0 cleared", ADDR_T0_REQ, 4'h0);
		rf(1'b1, ADDR_T0_REQ, 4'h1);
		rd_chk("t0 forced", ADDR_T0_REQ, 4'h1);
		rf(1'b1, ADDR_T0_REQ, 4'h0);
		rd_chk("t0 cancel", ADDR_T0_REQ, 4'h0);
		// clock enable low: a forcing write must not land
		@(posedge i_clock) clk_en <= 1'b0;
		rf(1'b1, ADDR_T0_REQ, 4'h1);
		@(posedge i_clock) clk_en <= 1'b1;
		rd_chk("t0 frozen", ADDR_T0_REQ, 4'h0);
		$display("test timer0 done");
		// every edge mode: rise then fall, flag held once set
		for (int m = 0; m < 4; m++) begin
			rf(1'b1, ADDR_EDGE_SEL, 4'(m));
			rd_chk("edge sel", ADDR_EDGE_SEL, 4'(m));
			rf(1'b1, ADDR_EXT_REQ, 4'h0);
			@(posedge i_clock) i_ext_pin <= 1'b1;
			repeat (2) @(posedge i_clock);
			rd_chk("after rise", ADDR_EXT_REQ, {3'h0, exp_ev[m][1]});
			@(posedge i_clock) i_ext_pin <= 1'b0;
			repeat (2) @(posedge i_clock);
			rd_chk("after fall", ADDR_EXT_REQ, {3'h0, |exp_ev[m]});
		end
		$display("test edges done");
		give_verdict();
	end
endmodule
